/* File: tb_top.sv */
// self-checking bench for the tx/rx state control block
`default_nettype none
`include "trc_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, tx_addr, rx_addr;
    logic tx_req, cp_req, sd_req, rx_req, fill, tps, rps;
    logic tx_own, rx_own, uflow, d_tx_own, d_rx_own, sent, d_uf;
    logic [3:0] ack, lat;
    logic [2:0] rx_ev;
    int err_total, checks_done, n;
    trc_state_ctrl trc_state_ctrl_inst (.I_SYS_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_TX_DESC_REQ(tx_req),
        .O_TX_DESC_ADDR(tx_addr), .I_TX_DESC_ACK(ack[0]), .I_TX_DESC_OWN(d_tx_own),
        .O_TX_COPY_REQ(cp_req), .I_TX_COPY_DONE(ack[1]), .O_TX_SEND_REQ(sd_req),
        .I_TX_SENT(sent), .I_TX_UNDERFLOW(d_uf), .O_RX_DESC_REQ(rx_req),
        .O_RX_DESC_ADDR(rx_addr), .I_RX_DESC_ACK(ack[3]), .I_RX_DESC_OWN(d_rx_own),
        .I_RX_FRAME_START(rx_ev[0]), .O_RX_FILL(fill), .I_RX_FRAME_END(rx_ev[1]),
        .I_RX_BUF_FULL(rx_ev[2]), .O_TPS(tps), .O_RPS(rps));
    trc_host_model trc_host_model_inst (.i_clk(clk), .i_nrst(nrst),
        .i_req({rx_req, sd_req, cp_req, tx_req}), .i_lat(lat), .i_tx_own(tx_own),
        .i_rx_own(rx_own), .i_uflow(uflow), .o_ack(ack), .o_tx_own(d_tx_own),
        .o_rx_own(d_rx_own), .o_sent(sent), .o_uflow(d_uf));
    task automatic close_out;
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        ck(q, e);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
    endtask
    // link events are single-cycle pulses
    task automatic ev(input int k);
        @(posedge clk);
        rx_ev[k] <= 1'b1;
        @(posedge clk);
        rx_ev[k] <= 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #1000000;
        err_total++;
        close_out;
    end
    initial begin
        {nrst, psel, penable, pwrite, tx_own, uflow, rx_ev} = '0;
        {paddr, pwdata, err_total, checks_done} = '0;
        rx_own = 1'b1;
        lat = 4'h2;
        wt(8);
        nrst <= 1'b1;
        ck({tps, rps}, 32'h3);
        rc(`TRC_OFS_STATUS, 32'h101);
        wr(`TRC_OFS_BUS_MODE, 32'h20000);
        wr(`TRC_OFS_TX_BASE, 32'h100);
        wr(`TRC_OFS_OP_MODE, 32'h2000);
        wt(20);
        rc(`TRC_OFS_STATUS, 32'h110);
        rc(`TRC_OFS_TX_CUR, 32'h100);
        ck(tps, 32'h0);
        wr(`TRC_OFS_OP_MODE, 32'h2000);
        rc(`TRC_OFS_STATUS, 32'h110);
        rc(`TRC_OFS_TX_CUR, 32'h100);
        tx_own <= 1'b1;
        uflow <= 1'b1;
        wr(`TRC_OFS_TX_POLL, 32'h1);
        wt(20);
        rc(`TRC_OFS_STATUS, 32'h10110);
        rc(`TRC_OFS_TX_CUR, 32'h100);
        // frames would now run endlessly, so a stray auto poll shows
        uflow <= 1'b0;
        wt(1100);
        rc(`TRC_OFS_STATUS, 32'h10110);
        wr(`TRC_OFS_TX_POLL, 32'h1);
        while (tx_addr !== 32'h110) @(posedge clk);
        tx_own <= 1'b0;
        wt(10);
        rc(`TRC_OFS_STATUS, 32'h110);
        rc(`TRC_OFS_TX_CUR, 32'h110);
        n = 0;
        while (tx_req !== 1'b1 && n < 1200) begin
            @(posedge clk);
            n++;
        end
        ck(n < 1100, 32'h1);
        ck(tx_addr, 32'h110);
        wr(`TRC_OFS_OP_MODE, 32'h0);
        wt(2);
        ck(tps, 32'h1);
        rc(`TRC_OFS_TX_CUR, 32'h110);
        wr(`TRC_OFS_TX_BASE, 32'h300);
        rc(`TRC_OFS_TX_CUR, 32'h300);
        lat <= 4'h0;
        wr(`TRC_OFS_RX_BASE, 32'h200);
        wr(`TRC_OFS_OP_MODE, 32'h2);
        wt(10);
        rc(`TRC_OFS_STATUS, 32'h401);
        ck(rx_addr, 32'h200);
        ev(0);
        wr(`TRC_OFS_OP_MODE, 32'h0);
        wt(5);
        ck({rps, fill}, 32'h1);
        rc(`TRC_OFS_STATUS, 32'h20801);
        ev(1);
        wt(2);
        ck(rps, 32'h1);
        rc(`TRC_OFS_RX_CUR, 32'h210);
        rx_own <= 1'b0;
        wr(`TRC_OFS_OP_MODE, 32'h2);
        wt(10);
        rc(`TRC_OFS_STATUS, 32'h1001);
        rx_own <= 1'b1;
        wr(`TRC_OFS_RX_POLL, 32'h1);
        wt(5);
        rc(`TRC_OFS_STATUS, 32'h401);
        rx_own <= 1'b0;
        ev(0);
        ev(2);
        wt(5);
        rc(`TRC_OFS_STATUS, 32'h1001);
        rc(`TRC_OFS_RX_CUR, 32'h220);
        rx_own <= 1'b1;
        ev(0);
        wt(5);
        rc(`TRC_OFS_STATUS, 32'h401);
        wr(`TRC_OFS_BUS_MODE, 32'h1);
        wt(3);
        ck({tps, rps}, 32'h3);
        rc(`TRC_OFS_RX_CUR, 32'h0);
        rc(`TRC_OFS_TX_CUR, 32'h0);
        rc(`TRC_OFS_BUS_MODE, 32'h0);
        rc(8'h40, 32'h0);
        ck(pslverr, 32'h1);
        close_out;
    end
endmodule // tb_top
`default_nettype wire

/* File: trc_chk.sv */
// port assertions for the tx/rx state control block
`default_nettype none
module trc_chk (
    input wire I_SYS_CLK,
    input wire I_NRST,
    input wire O_TPS,
    input wire O_RPS,
    input wire O_TX_DESC_REQ,
    input wire O_TX_COPY_REQ,
    input wire O_TX_SEND_REQ,
    input wire [31:0] O_TX_DESC_ADDR,
    input wire I_TX_DESC_ACK,
    input wire I_TX_DESC_OWN,
    input wire I_TX_SENT,
    input wire I_TX_UNDERFLOW,
    input wire O_RX_DESC_REQ,
    input wire O_RX_FILL,
    input wire [31:0] O_RX_DESC_ADDR,
    input wire I_RX_DESC_ACK,
    input wire I_RX_DESC_OWN,
    input wire I_RX_FRAME_END,
    input wire I_RX_BUF_FULL
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    wire tx_ack = O_TX_DESC_REQ && I_TX_DESC_ACK;
    wire rx_ack = O_RX_DESC_REQ && I_RX_DESC_ACK;
    wire rx_close = O_RX_FILL && (I_RX_FRAME_END || I_RX_BUF_FULL);
    a_tx_halted: assert property (O_TPS |-> !(O_TX_DESC_REQ || O_TX_COPY_REQ || O_TX_SEND_REQ))
        else $error("tx request while stopped");
    a_rx_halted: assert property (O_RPS |-> !(O_RX_DESC_REQ || O_RX_FILL))
        else $error("rx request while stopped");
    a_tx_copy: assert property (tx_ack && I_TX_DESC_OWN |=> O_TX_COPY_REQ)
        else $error("no copy after owned descriptor");
    a_tx_host: assert property (tx_ack && !I_TX_DESC_OWN |=>
        !O_TPS && !O_TX_DESC_REQ && $stable(O_TX_DESC_ADDR)) else $error("tx host descriptor");
    a_tx_next: assert property (O_TX_SEND_REQ && I_TX_SENT && !I_TX_UNDERFLOW |=>
        O_TX_DESC_REQ && O_TX_DESC_ADDR == $past(O_TX_DESC_ADDR) + 32'h10)
        else $error("tx next fetch wrong");
    a_tx_uflow: assert property (O_TX_SEND_REQ && I_TX_UNDERFLOW |=>
        (!O_TPS && !O_TX_DESC_REQ && $stable(O_TX_DESC_ADDR)) [*8]) else $error("tx underflow");
    a_rx_wait: assert property (rx_ack && I_RX_DESC_OWN |=>
        !O_RX_DESC_REQ && !O_RX_FILL && !O_RPS) else $error("rx not waiting");
    a_rx_host: assert property (rx_ack && !I_RX_DESC_OWN |=>
        !O_RPS && !O_RX_DESC_REQ && $stable(O_RX_DESC_ADDR)) else $error("rx host descriptor");
    a_rx_close: assert property (rx_close |=> !O_RX_FILL && (O_RX_DESC_REQ != O_RPS) &&
        O_RX_DESC_ADDR == $past(O_RX_DESC_ADDR) + 32'h10) else $error("rx close wrong");
    a_rx_finish: assert property (O_RX_FILL && !I_RX_FRAME_END && !I_RX_BUF_FULL |=>
        O_RX_FILL) else $error("rx frame cut short");
    c_tx_sent: cover property (O_TX_SEND_REQ && I_TX_SENT);
    c_tx_uflow: cover property (O_TX_SEND_REQ && I_TX_UNDERFLOW);
    c_rx_close: cover property (rx_close);
endmodule // trc_chk
bind trc_state_ctrl trc_chk trc_chk_inst (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
    .O_TPS(O_TPS), .O_RPS(O_RPS), .O_TX_DESC_REQ(O_TX_DESC_REQ),
    .O_TX_COPY_REQ(O_TX_COPY_REQ), .O_TX_SEND_REQ(O_TX_SEND_REQ),
    .O_TX_DESC_ADDR(O_TX_DESC_ADDR), .I_TX_DESC_ACK(I_TX_DESC_ACK),
    .I_TX_DESC_OWN(I_TX_DESC_OWN), .I_TX_SENT(I_TX_SENT), .I_TX_UNDERFLOW(I_TX_UNDERFLOW),
    .O_RX_DESC_REQ(O_RX_DESC_REQ), .O_RX_FILL(O_RX_FILL), .O_RX_DESC_ADDR(O_RX_DESC_ADDR),
    .I_RX_DESC_ACK(I_RX_DESC_ACK), .I_RX_DESC_OWN(I_RX_DESC_OWN),
    .I_RX_FRAME_END(I_RX_FRAME_END), .I_RX_BUF_FULL(I_RX_BUF_FULL));
`default_nettype wire

/* File: trc_host_model.sv */
// behavioural host answering descriptor and data requests
`default_nettype none
module trc_host_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_req,
    input wire logic [3:0] i_lat,
    input wire logic i_tx_own,
    input wire logic i_rx_own,
    input wire logic i_uflow,
    output logic [3:0] o_ack,
    output logic o_tx_own,
    output logic o_rx_own,
    output logic o_sent,
    output logic o_uflow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg [4];
    // ack is one cycle; the request drops on the edge that samples it
    always @(posedge i_clk or negedge i_nrst) begin
        for (int k = 0; k < 4; k++) begin
            if (!i_nrst) begin
                o_ack[k] <= 1'b0;
                cnt_reg[k] <= 4'h0;
            end else begin
                o_ack[k] <= 1'b0;
                cnt_reg[k] <= 4'h0;
                if (i_req[k] && !o_ack[k]) begin
                    if (cnt_reg[k] >= i_lat) begin
                        o_ack[k] <= 1'b1;
                    end else begin
                        cnt_reg[k] <= cnt_reg[k] + 4'h1;
                    end
                end
            end
        end
    end
    // owner bit is only meaningful with its ack, so show garbage otherwise
    assign o_tx_own = o_ack[0] ? i_tx_own : ~i_tx_own;
    assign o_rx_own = o_ack[3] ? i_rx_own : ~i_rx_own;
    assign o_sent = o_ack[2] & ~i_uflow;
    assign o_uflow = o_ack[2] & i_uflow;
endmodule // trc_host_model
`default_nettype wire

/* File: trc_regs.vh */
// register map, field positions and reset values for the tx/rx state control block
`ifndef TRC_REGS_VH
`define TRC_REGS_VH

// register byte offsets
`define TRC_OFS_BUS_MODE 8'h00
`define TRC_OFS_TX_POLL 8'h04
`define TRC_OFS_RX_POLL 8'h08
`define TRC_OFS_RX_BASE 8'h0C
`define TRC_OFS_TX_BASE 8'h10
`define TRC_OFS_OP_MODE 8'h18
`define TRC_OFS_STATUS 8'h1C
`define TRC_OFS_TX_CUR 8'h20
`define TRC_OFS_RX_CUR 8'h24

// bus_mode_reg fields
`define TRC_BM_SOFT_RESET 0
`define TRC_BM_TAP_LO 17
`define TRC_BM_TAP_HI 19

// operation_mode_reg fields
`define TRC_OM_RX_RUN 1
`define TRC_OM_TX_RUN 13

// status register fields
`define TRC_ST_TX_LO 0
`define TRC_ST_TX_HI 4
`define TRC_ST_RX_LO 8
`define TRC_ST_RX_HI 12
`define TRC_ST_UNDERFLOW 16
`define TRC_ST_RX_STOP_PEND 17

// reset values
`define TRC_RST_BUS_MODE 32'h00000000
`define TRC_RST_OP_MODE 32'h00000000
`define TRC_RST_DESC_BASE 32'h00000000

// descriptor stride in bytes
`define TRC_DESC_STRIDE 32'h00000010

// auto poll: interval is tap value times 1024 clock cycles
`define TRC_POLL_UNIT_BITS 10
`define TRC_POLL_CNT_W 13

`endif

/* File: trc_state_ctrl.v */
// transmit and receive process state control with apb register access
//
// Overview of operation
// - tx stops on reset or stop command; leaves stopped only on start command.
// - stopped or suspended tx keeps next descriptor address for the next fetch.
// - writing tx descriptor base points the next tx fetch at the list start.
// - tx halted output is high while tx is stopped.
// - soft reset bit restores all registers and drops both descriptor positions.
// - clearing tx run bit stops tx from running or suspended, keeping position.
// - tx fetch of a host-owned descriptor stops running, keeping position.
// - tx underflow flags error, suspends, keeps position, disables auto polling.
// - nonzero write to tx poll demand moves tx from suspended to running.
// - auto poll only with nonzero interval and no underflow before suspension.
// - running tx fetches descriptor, copies frame data, then sends the frame.
// - rx stops on reset or stop command; leaves stopped only on start command.
// - running rx fetches a descriptor without a frame and waits holding it.
// - rx fills buffers, closes descriptor at end or full, fetches next at once.
// - stopped or suspended rx keeps next descriptor address for the next fetch.
// - writing rx descriptor base points next rx fetch at list start, when stopped.
// - rx halted output is high while rx is stopped.
// - clearing rx run bit issues stop receive, keeping position.
// - rx fetch of a host-owned descriptor stops running, keeping position.
// - rx leaves suspended on nonzero rx poll demand write or a new frame.
// - stop receive during a frame takes effect only after that frame ends or its buffer fills.
//
// Decided for this implementation: the APB slave port and the address map.
`default_nettype none

`include "trc_regs.vh"

module trc_state_ctrl (
    input wire I_SYS_CLK,
    input wire I_NRST,
    // apb slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output wire O_PREADY,
    output reg [31:0] O_PRDATA,
    output reg O_PSLVERR,
    // transmit descriptor and data engine
    output wire O_TX_DESC_REQ,
    output wire [31:0] O_TX_DESC_ADDR,
    input wire I_TX_DESC_ACK,
    input wire I_TX_DESC_OWN,
    output wire O_TX_COPY_REQ,
    input wire I_TX_COPY_DONE,
    output wire O_TX_SEND_REQ,
    input wire I_TX_SENT,
    input wire I_TX_UNDERFLOW,
    // receive descriptor and data engine
    output wire O_RX_DESC_REQ,
    output wire [31:0] O_RX_DESC_ADDR,
    input wire I_RX_DESC_ACK,
    input wire I_RX_DESC_OWN,
    input wire I_RX_FRAME_START,
    output wire O_RX_FILL,
    input wire I_RX_FRAME_END,
    input wire I_RX_BUF_FULL,
    // process stopped outputs for external clock gating
    output wire O_TPS,
    output wire O_RPS
);

    localparam [4:0] TX_STOP = 5'b00001;
    localparam [4:0] TX_FETCH = 5'b00010;
    localparam [4:0] TX_COPY = 5'b00100;
    localparam [4:0] TX_SEND = 5'b01000;
    localparam [4:0] TX_SUSP = 5'b10000;

    localparam [4:0] RX_STOP = 5'b00001;
    localparam [4:0] RX_FETCH = 5'b00010;
    localparam [4:0] RX_WAIT = 5'b00100;
    localparam [4:0] RX_FILL = 5'b01000;
    localparam [4:0] RX_SUSP = 5'b10000;

    reg [31:0] bus_mode_reg;
    reg [31:0] operation_mode_reg;
    reg [31:0] tx_desc_base_reg;
    reg [31:0] rx_desc_base_reg;
    reg [31:0] tx_ptr_reg;
    reg [31:0] tx_ptr_next;
    reg [31:0] rx_ptr_reg;
    reg [31:0] rx_ptr_next;
    reg [4:0] tx_state_reg;
    reg [4:0] tx_state_next;
    reg [4:0] rx_state_reg;
    reg [4:0] rx_state_next;
    reg underflow_reg;
    reg underflow_next;
    reg rx_stop_pend_reg;
    reg rx_stop_pend_next;
    reg soft_reset_reg;
    reg [`TRC_POLL_CNT_W-1:0] poll_cnt_reg;
    reg [`TRC_POLL_CNT_W-1:0] poll_cnt_next;
    reg [31:0] rdata_next;
    reg addr_ok;

    wire wr_en = I_PSEL & I_PENABLE & I_PWRITE;
    wire rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
    wire nz_data = |I_PWDATA;
    wire tx_poll_wr = wr_en & (I_PADDR == `TRC_OFS_TX_POLL) & nz_data;
    wire rx_poll_wr = wr_en & (I_PADDR == `TRC_OFS_RX_POLL) & nz_data;
    wire tx_base_wr = wr_en & (I_PADDR == `TRC_OFS_TX_BASE);
    wire rx_base_wr = wr_en & (I_PADDR == `TRC_OFS_RX_BASE);
    wire tx_run = operation_mode_reg[`TRC_OM_TX_RUN];
    wire rx_run = operation_mode_reg[`TRC_OM_RX_RUN];
    wire [2:0] tap = bus_mode_reg[`TRC_BM_TAP_HI:`TRC_BM_TAP_LO];
    // whole 1024-cycle units; the counter restarts from zero on every entry to suspend
    // so a poll comes exactly tap units after suspension, never a unit early or late
    wire [`TRC_POLL_CNT_W-1:0] poll_limit = {tap, {`TRC_POLL_UNIT_BITS{1'b0}}};
    // underflow keeps auto poll off until the host polls or restarts tx
    wire auto_poll_en = (tap != 3'h0) & ~underflow_reg;
    wire auto_poll = auto_poll_en & (tx_state_reg == TX_SUSP) & (poll_cnt_reg == poll_limit);

    // zero wait state slave; read data captured in the setup cycle
    assign O_PREADY = 1'b1;

    always @* begin
        addr_ok = 1'b1;
        rdata_next = 32'h00000000;
        case (I_PADDR)
            `TRC_OFS_BUS_MODE: begin
                rdata_next = bus_mode_reg;
            end
            `TRC_OFS_TX_POLL: begin
                rdata_next = 32'h00000000;
            end
            `TRC_OFS_RX_POLL: begin
                rdata_next = 32'h00000000;
            end
            `TRC_OFS_RX_BASE: begin
                rdata_next = rx_desc_base_reg;
            end
            `TRC_OFS_TX_BASE: begin
                rdata_next = tx_desc_base_reg;
            end
            `TRC_OFS_OP_MODE: begin
                rdata_next = operation_mode_reg;
            end
            `TRC_OFS_STATUS: begin
                rdata_next[`TRC_ST_TX_HI:`TRC_ST_TX_LO] = tx_state_reg;
                rdata_next[`TRC_ST_RX_HI:`TRC_ST_RX_LO] = rx_state_reg;
                rdata_next[`TRC_ST_UNDERFLOW] = underflow_reg;
                rdata_next[`TRC_ST_RX_STOP_PEND] = rx_stop_pend_reg;
            end
            `TRC_OFS_TX_CUR: begin
                rdata_next = tx_ptr_reg;
            end
            `TRC_OFS_RX_CUR: begin
                rdata_next = rx_ptr_reg;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end else begin
            if (rd_setup) begin
                O_PRDATA <= rdata_next;
            end
            if (I_PSEL & ~I_PENABLE) begin
                O_PSLVERR <= ~addr_ok;
            end
        end
    end

    // soft reset is held one cycle, then clears everything including itself
    // state machines see it on the same edge as the registers, so the host must leave one idle
    // cycle after the write before its next access
    always @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            bus_mode_reg <= `TRC_RST_BUS_MODE;
            operation_mode_reg <= `TRC_RST_OP_MODE;
            tx_desc_base_reg <= `TRC_RST_DESC_BASE;
            rx_desc_base_reg <= `TRC_RST_DESC_BASE;
            soft_reset_reg <= 1'b0;
        end else if (soft_reset_reg) begin
            bus_mode_reg <= `TRC_RST_BUS_MODE;
            operation_mode_reg <= `TRC_RST_OP_MODE;
            tx_desc_base_reg <= `TRC_RST_DESC_BASE;
            rx_desc_base_reg <= `TRC_RST_DESC_BASE;
            soft_reset_reg <= 1'b0;
        end else if (wr_en) begin
            case (I_PADDR)
                `TRC_OFS_BUS_MODE: begin
                    bus_mode_reg <= I_PWDATA;
                    soft_reset_reg <= I_PWDATA[`TRC_BM_SOFT_RESET];
                end
                `TRC_OFS_OP_MODE: begin
                    operation_mode_reg <= I_PWDATA;
                end
                `TRC_OFS_TX_BASE: begin
                    tx_desc_base_reg <= I_PWDATA;
                end
                `TRC_OFS_RX_BASE: begin
                    rx_desc_base_reg <= I_PWDATA;
                end
                default: begin
                    soft_reset_reg <= 1'b0;
                end
            endcase
        end
    end

    // transmit process
    always @* begin
        tx_state_next = tx_state_reg;
        tx_ptr_next = tx_ptr_reg;
        underflow_next = underflow_reg;
        poll_cnt_next = `TRC_POLL_CNT_W'd0;
        case (tx_state_reg)
            TX_STOP: begin
                // start is a level, only looked at here, so a repeated start is harmless
                if (tx_run) begin
                    tx_state_next = TX_FETCH;
                    underflow_next = 1'b0;
                end
            end
            TX_FETCH: begin
                if (I_TX_DESC_ACK) begin
                    if (I_TX_DESC_OWN) begin
                        tx_state_next = TX_COPY;
                    end else begin
                        tx_state_next = TX_SUSP;
                    end
                end
            end
            TX_COPY: begin
                if (I_TX_COPY_DONE) begin
                    tx_state_next = TX_SEND;
                end
            end
            TX_SEND: begin
                // underflow wins over sent in one cycle; that frame is not closed
                if (I_TX_UNDERFLOW) begin
                    tx_state_next = TX_SUSP;
                    underflow_next = 1'b1;
                end else if (I_TX_SENT) begin
                    tx_state_next = TX_FETCH;
                    tx_ptr_next = tx_ptr_reg + `TRC_DESC_STRIDE;
                end
            end
            TX_SUSP: begin
                if (auto_poll_en) begin
                    poll_cnt_next = poll_cnt_reg + `TRC_POLL_CNT_W'd1;
                end
                if (tx_poll_wr || auto_poll) begin
                    tx_state_next = TX_FETCH;
                    underflow_next = 1'b0;
                end
            end
            default: begin
                tx_state_next = TX_STOP;
            end
        endcase
        // stop from any active state; position kept
        if (!tx_run) begin
            tx_state_next = TX_STOP;
        end
        // base write is only legal while stopped, so it wins over the advance
        if (tx_base_wr) begin
            tx_ptr_next = I_PWDATA;
        end
    end

    // receive process
    always @* begin
        rx_state_next = rx_state_reg;
        rx_ptr_next = rx_ptr_reg;
        rx_stop_pend_next = rx_stop_pend_reg;
        case (rx_state_reg)
            RX_STOP: begin
                rx_stop_pend_next = 1'b0;
                if (rx_run) begin
                    rx_state_next = RX_FETCH;
                end
            end
            RX_FETCH: begin
                if (!rx_run) begin
                    rx_state_next = RX_STOP;
                end else if (I_RX_DESC_ACK) begin
                    if (I_RX_DESC_OWN) begin
                        rx_state_next = RX_WAIT;
                    end else begin
                        rx_state_next = RX_SUSP;
                    end
                end
            end
            RX_WAIT: begin
                if (!rx_run) begin
                    rx_state_next = RX_STOP;
                end else if (I_RX_FRAME_START) begin
                    rx_state_next = RX_FILL;
                end
            end
            RX_FILL: begin
                // stop is remembered, so setting run again mid-frame still stops
                if (!rx_run) begin
                    rx_stop_pend_next = 1'b1;
                end
                if (I_RX_FRAME_END || I_RX_BUF_FULL) begin
                    rx_ptr_next = rx_ptr_reg + `TRC_DESC_STRIDE;
                    if (!rx_run || rx_stop_pend_reg) begin
                        rx_state_next = RX_STOP;
                    end else begin
                        rx_state_next = RX_FETCH;
                    end
                end
            end
            RX_SUSP: begin
                if (!rx_run) begin
                    rx_state_next = RX_STOP;
                end else if (rx_poll_wr || I_RX_FRAME_START) begin
                    rx_state_next = RX_FETCH;
                end
            end
            default: begin
                rx_state_next = RX_STOP;
            end
        endcase
        if (rx_base_wr) begin
            rx_ptr_next = I_PWDATA;
        end
    end

    always @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tx_state_reg <= TX_STOP;
            rx_state_reg <= RX_STOP;
            tx_ptr_reg <= `TRC_RST_DESC_BASE;
            rx_ptr_reg <= `TRC_RST_DESC_BASE;
            underflow_reg <= 1'b0;
            rx_stop_pend_reg <= 1'b0;
            poll_cnt_reg <= `TRC_POLL_CNT_W'd0;
        end else if (soft_reset_reg) begin
            tx_state_reg <= TX_STOP;
            rx_state_reg <= RX_STOP;
            tx_ptr_reg <= `TRC_RST_DESC_BASE;
            rx_ptr_reg <= `TRC_RST_DESC_BASE;
            underflow_reg <= 1'b0;
            rx_stop_pend_reg <= 1'b0;
            poll_cnt_reg <= `TRC_POLL_CNT_W'd0;
        end else begin
            tx_state_reg <= tx_state_next;
            rx_state_reg <= rx_state_next;
            tx_ptr_reg <= tx_ptr_next;
            rx_ptr_reg <= rx_ptr_next;
            underflow_reg <= underflow_next;
            rx_stop_pend_reg <= rx_stop_pend_next;
            poll_cnt_reg <= poll_cnt_next;
        end
    end

    // requests are one-hot state bits, so they come glitch free from flops
    assign O_TX_DESC_REQ = tx_state_reg[1];
    assign O_TX_DESC_ADDR = tx_ptr_reg;
    assign O_TX_COPY_REQ = tx_state_reg[2];
    assign O_TX_SEND_REQ = tx_state_reg[3];
    assign O_RX_DESC_REQ = rx_state_reg[1];
    assign O_RX_DESC_ADDR = rx_ptr_reg;
    assign O_RX_FILL = rx_state_reg[3];
    assign O_TPS = tx_state_reg[0];
    assign O_RPS = rx_state_reg[0];

endmodule // trc_state_ctrl

`default_nettype wire
